// ### core/vlcs_pkg.sv
// shared constants and code table for the variable-length code store
package vlcs_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int          ADDR_W     = 6;
  localparam int          LEN_W      = 4;
  localparam int          GEN_W      = 8;
  localparam int          FIFO_DEPTH = 16;
  localparam logic [7:0]  GEN_RESET  = 8'h01;
  // serial link: mclk cycles per half phase of the outgoing data clock
  localparam logic [1:0]  DCLK_HALF  = 2'h2;

  // ****************************************
  // controller states, 2-stage johnson order
  // ****************************************
  typedef enum logic [1:0] {
    VLCS_IDLE   = 2'h0,
    VLCS_WAIT   = 2'h1,
    VLCS_SEARCH = 2'h3,
    VLCS_SHIFT  = 2'h2
  } vlcs_state_t;

  // returns {length, code left-aligned}; length zero marks an unused address
  function automatic logic [11:0] code_lookup(input logic [5:0] a);
    logic [11:0] r;
    r = 12'h000;
    case (a)
      6'h00: r = {4'h2, 8'h00};
      6'h01: r = {4'h3, 8'ha0};
      6'h02: r = {4'h3, 8'hc0};
      6'h03: r = {4'h4, 8'h50};
      6'h04: r = {4'h4, 8'h60};
      6'h05: r = {4'h4, 8'h80};
      6'h06: r = {4'h5, 8'h98};
      6'h07: r = {4'h5, 8'he8};
      6'h08: r = {4'h6, 8'h44};
      6'h09: r = {4'h6, 8'h48};
      6'h0a: r = {4'h6, 8'h70};
      6'h0b: r = {4'h6, 8'h78};
      6'h0c: r = {4'h6, 8'hf8};
      6'h0d: r = {4'h6, 8'hf0};
      6'h0e: r = {4'h6, 8'hf4};
      6'h0f: r = {4'h7, 8'h42};
      6'h10: r = {4'h7, 8'h4c};
      6'h11: r = {4'h7, 8'h4e};
      6'h12: r = {4'h7, 8'h74};
      6'h13: r = {4'h7, 8'h76};
      6'h14: r = {4'h7, 8'h7e};
      6'h15: r = {4'h7, 8'h7c};
      6'h16: r = {4'h7, 8'h90};
      6'h17: r = {4'h7, 8'h92};
      6'h18: r = {4'h7, 8'h94};
      6'h19: r = {4'h7, 8'h96};
      6'h1a: r = {4'h7, 8'he0};
      6'h1b: r = {4'h7, 8'hc2};
      6'h1c: r = {4'h7, 8'he0};
      6'h1d: r = {4'h7, 8'he2};
      6'h1e: r = {4'h7, 8'hfe};
      6'h1f: r = {4'h7, 8'hfc};
      6'h20: r = {4'h8, 8'h40};
      6'h21: r = {4'h8, 8'h41};
      default: r = 12'h000;
    endcase
    return r;
  endfunction : code_lookup

endpackage : vlcs_pkg

// ### core/vlcs_store.sv
// variable-length code store: bit fifo and the generator-based code controller
`timescale 1ns/1ns

// ****************************************
// bit fifo
// ****************************************
module vlcs_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } vlcs_fifo_st_t;

  vlcs_fifo_st_t f_q, f_d;
  logic          full, empty;

  always_comb begin
    full      = (f_q.wp[AW] != f_q.rp[AW]) && (f_q.wp[AW-1:0] == f_q.rp[AW-1:0]);
    empty     = (f_q.wp == f_q.rp);
    in_ready  = !full;
    out_valid = !empty;
    out_data  = f_q.mem[f_q.rp[AW-1:0]];
    f_d       = f_q;
    if (in_valid && !full) begin
      f_d.mem[f_q.wp[AW-1:0]] = in_data;
      f_d.wp                  = f_q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      f_d.rp = f_q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule : vlcs_fifo

// How it works
// - an 8-stage maximal-length generator steps through all 255 nonzero states unless held.
// - the generator's first stage takes the xor of stages 8, 4, 3 and 2.
// - after reset the controller sits idle and shows host_ready while idle.
// - the host writes a 6-bit address with the strobe, which is registered and moves idle to wait.
// - wait holds until the registered strobe falls; its inverse rises, then search follows.
// - state steps in 2-stage johnson order except the jump from search to idle on an unused address; matching is only allowed in the search state.
// - search compares the address's code with the last L generator stages, L its length.
// - a match loads the length counter, holds the generator and moves to shift.
// - in shift the generator steps again to push the held code into the bit fifo, which the data clock drains.
// - each bit sent steps the length counter down so exactly L bits leave.
// - when the counter reaches its end the controller returns to idle.
// - each code leaves leftmost bit first, from generator stage 8.
module vlcs_store (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // host port
  input  wire logic       host_write_strobe,
  input  wire logic [5:0] host_addr,
  output logic            host_ready,
  // serial link
  output logic            ser_data,
  output logic            ser_clk
);

  typedef struct packed {
    logic                   stb_meta;
    logic                   stb_sync;
    logic [5:0]             addr_meta;
    logic [5:0]             addr_sync;
    logic                   stb;
    logic                   stb_n;
    logic [5:0]             addr;
    vlcs_pkg::vlcs_state_t  fsm;
    logic [7:0]             gen;
    logic [3:0]             cnt;
    logic                   ready;
    logic [1:0]             div;
    logic                   dbusy;
    logic                   data;
    logic                   dclk;
  } vlcs_st_t;

  vlcs_st_t    st_q, st_d;
  logic [11:0] entry;
  logic [3:0]  code_length_word;
  logic [7:0]  mask;
  logic        code_match_found;
  logic        feedback;
  logic        push, fifo_ready, pop, bit_valid, bit_out, tick;

  // ****************************************
  // output bit buffer
  // ****************************************
  // a stalled drain holds the shift state, so no generator step is lost
  vlcs_fifo #(.WIDTH(1), .DEPTH(vlcs_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (mclk),
    .rst_n     (rst_n),
    .in_data   (st_q.gen[7]),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (bit_out),
    .out_valid (bit_valid),
    .out_ready (pop)
  );

  // ****************************************
  // controller
  // ****************************************
  always_comb begin
    st_d             = st_q;
    entry            = vlcs_pkg::code_lookup(st_q.addr);
    code_length_word = entry[11:8];
    mask             = 8'hff << (4'h8 - code_length_word);
    feedback         = st_q.gen[7] ^ st_q.gen[3] ^ st_q.gen[2] ^ st_q.gen[1];
    code_match_found = (st_q.fsm == vlcs_pkg::VLCS_SEARCH) && (code_length_word != 4'h0)
                       && (((st_q.gen ^ entry[7:0]) & mask) == 8'h00);
    push             = (st_q.fsm == vlcs_pkg::VLCS_SHIFT) && fifo_ready;
    tick             = (st_q.div == vlcs_pkg::DCLK_HALF - 2'h1);
    pop              = tick && !st_q.dbusy && bit_valid;

    // pin inputs pass two flip-flops first
    st_d.stb_meta  = host_write_strobe;
    st_d.stb_sync  = st_q.stb_meta;
    st_d.addr_meta = host_addr;
    st_d.addr_sync = st_q.addr_meta;
    st_d.stb       = st_q.stb_sync;
    st_d.stb_n   = !st_q.stb;

    // generator steps freely except on the match cycle and on a stalled shift
    if (!code_match_found && ((st_q.fsm != vlcs_pkg::VLCS_SHIFT) || push)) begin
      st_d.gen = {st_q.gen[6:0], feedback};
    end

    case (st_q.fsm)
      vlcs_pkg::VLCS_IDLE: begin
        if (st_q.stb) begin
          st_d.addr = st_q.addr_sync;
          st_d.fsm  = vlcs_pkg::VLCS_WAIT;
        end
      end
      vlcs_pkg::VLCS_WAIT: begin
        if (st_q.stb_n) begin
          st_d.fsm = vlcs_pkg::VLCS_SEARCH;
        end
      end
      vlcs_pkg::VLCS_SEARCH: begin
        if (code_length_word == 4'h0) begin
          st_d.fsm = vlcs_pkg::VLCS_IDLE;
        end else if (code_match_found) begin
          st_d.cnt = code_length_word;
          st_d.fsm = vlcs_pkg::VLCS_SHIFT;
        end
      end
      vlcs_pkg::VLCS_SHIFT: begin
        if (push) begin
          st_d.cnt = st_q.cnt - 4'h1;
          if (st_q.cnt == 4'h1) begin
            st_d.fsm = vlcs_pkg::VLCS_IDLE;
          end
        end
      end
      default: st_d.fsm = vlcs_pkg::VLCS_IDLE;
    endcase
    st_d.ready = (st_d.fsm == vlcs_pkg::VLCS_IDLE);

    // serial drain: data set, clock rises one half later, falls after another
    st_d.div = tick ? 2'h0 : st_q.div + 2'h1;
    if (pop) begin
      st_d.data  = bit_out;
      st_d.dbusy = 1'b1;
    end else if (tick && st_q.dbusy && !st_q.dclk) begin
      st_d.dclk = 1'b1;
    end else if (tick && st_q.dclk) begin
      st_d.dclk  = 1'b0;
      st_d.dbusy = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.gen   <= vlcs_pkg::GEN_RESET;
      st_q.fsm   <= vlcs_pkg::VLCS_IDLE;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign host_ready = st_q.ready;
  assign ser_data   = st_q.data;
  assign ser_clk    = st_q.dclk;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  idle_ready_a: assert property (host_ready == (st_q.fsm == vlcs_pkg::VLCS_IDLE))
    else $error("ready does not follow idle state");
  strobe_wait_a: assert property (
    (st_q.fsm == vlcs_pkg::VLCS_IDLE) && st_q.stb |=> st_q.fsm == vlcs_pkg::VLCS_WAIT)
    else $error("strobe did not move idle to wait");
  wait_exit_a: assert property (
    (st_q.fsm == vlcs_pkg::VLCS_WAIT)
    |=> (st_q.fsm == ($past(st_q.stb_n) ? vlcs_pkg::VLCS_SEARCH : vlcs_pkg::VLCS_WAIT)))
    else $error("wait state left at wrong time");
  // sampled rst_n keeps the release edge out: the register still sits in reset there
  gen_step_a: assert property (
    rst_n && (st_q.fsm == vlcs_pkg::VLCS_IDLE)
    |=> st_q.gen == {$past(st_q.gen[6:0]), ^($past(st_q.gen) & 8'h8e)})
    else $error("generator step wrong");
  gen_nonzero_a: assert property (st_q.gen != 8'h00)
    else $error("generator locked at zero");
  match_load_a: assert property (
    code_match_found |=> (st_q.fsm == vlcs_pkg::VLCS_SHIFT)
    && (st_q.gen == $past(st_q.gen)) && (st_q.cnt == $past(code_length_word)))
    else $error("match did not load and hold");
  search_only_a: assert property (code_match_found |-> st_q.fsm == vlcs_pkg::VLCS_SEARCH)
    else $error("match outside search");
  shift_entry_a: assert property (
    (st_q.fsm != vlcs_pkg::VLCS_SEARCH) && (st_q.fsm != vlcs_pkg::VLCS_SHIFT)
    |=> st_q.fsm != vlcs_pkg::VLCS_SHIFT)
    else $error("shift entered from outside search");
  shift_count_a: assert property (
    push && (st_q.cnt != 4'h1) |=> st_q.cnt == $past(st_q.cnt) - 4'h1)
    else $error("length counter did not step");
  shift_end_a: assert property (
    push && (st_q.cnt == 4'h1) |=> st_q.fsm == vlcs_pkg::VLCS_IDLE ##1 host_ready)
    else $error("shift did not end after last bit");
  clk_after_data_a: assert property ($rose(ser_clk) |-> $stable(ser_data)[*2])
    else $error("data changed near clock edge");

  match_seen_c: cover property (code_match_found);
  shift_done_c: cover property (push && (st_q.cnt == 4'h1));
  fifo_full_c:  cover property (!fifo_ready);
  no_code_c:    cover property ((st_q.fsm == vlcs_pkg::VLCS_SEARCH) && (code_length_word == 4'h0));

endmodule : vlcs_store

// ### verif/vlcs_rx_model.sv
// synchronous serial receiver model that collects the code bits leaving the store
`timescale 1ns/1ns

// ****************************************
// serial receiver
// ****************************************
module vlcs_rx_model (
  // serial link from the store
  input wire logic ser_data,
  input wire logic ser_clk
);
  logic bits[$];
  int   hold_err;

  initial hold_err = 0;

  // bits arrive leftmost first, one per rising data clock
  always @(posedge ser_clk) begin
    bits.push_back(ser_data);
  end

  // a data change while the clock is high could be caught on either side by a real receiver
  always @(ser_data) begin
    if (ser_clk === 1'b1) begin
      hold_err = hold_err + 1;
    end
  end
endmodule : vlcs_rx_model

// ### verif/vlcs_store_tb.sv
// self-checking testbench for the variable-length code store
`timescale 1ns/1ns
module vlcs_store_tb;
  // ****************************************
  // clock, reset and design
  // ****************************************
  logic       mclk;
  logic       rst_n;
  logic       host_write_strobe;
  logic [5:0] host_addr;
  logic       host_ready;
  logic       ser_data;
  logic       ser_clk;
  int         bad_count;
  int         cmp_count;
  logic       exp_bits[$];

  vlcs_store uut (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .host_write_strobe (host_write_strobe),
    .host_addr         (host_addr),
    .host_ready        (host_ready),
    .ser_data          (ser_data),
    .ser_clk           (ser_clk)
  );

  vlcs_rx_model rx (
    .ser_data (ser_data),
    .ser_clk  (ser_clk)
  );

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // host write: address stays put for the whole strobe and past it
  task automatic write_code(input logic [5:0] a, input int len, input logic [7:0] code);
    int n;
    @(posedge mclk);
    host_addr         <= a;
    host_write_strobe <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check("ready early", 8'h01, {7'h00, host_ready});
    repeat (2) @(posedge mclk);
    host_write_strobe <= 1'b0;
    n = 0;
    while (host_ready !== 1'b0 && n < 8) begin
      @(posedge mclk);
      #1 n++;
    end
    check("ready fall", 8'h00, {7'h00, host_ready});
    n = 0;
    while (host_ready !== 1'b1 && n < 700) begin
      @(posedge mclk);
      #1 n++;
    end
    check("ready back", 8'h01, {7'h00, host_ready});
    for (int i = 0; i < len; i++) begin
      exp_bits.push_back(code[7-i]);
    end
  endtask : write_code

  // waits for the expected bits, then a quiet spell so a surplus bit shows up
  task automatic check_stream;
    int n;
    n = 0;
    while (rx.bits.size() < exp_bits.size() && n < 800) begin
      @(posedge mclk);
      n++;
    end
    repeat (40) @(posedge mclk);
    check("bit count", 8'(exp_bits.size()), 8'(rx.bits.size()));
    for (int i = 0; i < exp_bits.size() && i < rx.bits.size(); i++) begin
      check("code bit", {7'h00, exp_bits[i]}, {7'h00, rx.bits[i]});
    end
    check("data hold", 8'h00, 8'(rx.hold_err));
    exp_bits.delete();
    rx.bits.delete();
  endtask : check_stream

  // ****************************************
  // scenarios
  // ****************************************
  task automatic single_codes;
    logic [5:0] a[8] = '{6'h00, 6'h01, 6'h05, 6'h07, 6'h0c, 6'h1a, 6'h20, 6'h28};
    int         l[8] = '{2, 3, 4, 5, 6, 7, 8, 0};
    logic [7:0] c[8] = '{8'h00, 8'ha0, 8'h80, 8'he8, 8'hf8, 8'he0, 8'h40, 8'h00};
    for (int i = 0; i < 8; i++) begin
      write_code(a[i], l[i], c[i]);
      check_stream();
    end
  endtask : single_codes

  // next address written while the previous code is still leaving
  task automatic back_to_back;
    write_code(6'h21, 8, 8'h41);
    write_code(6'h03, 4, 8'h50);
    write_code(6'h14, 7, 8'h7e);
    check_stream();
  endtask : back_to_back

  task automatic reset_mid_shift;
    int n;
    write_code(6'h21, 8, 8'h41);
    n = 0;
    while (rx.bits.size() < 2 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check("reset ready", 8'h01, {7'h00, host_ready});
    check("reset sclk", 8'h00, {7'h00, ser_clk});
    check("reset data", 8'h00, {7'h00, ser_data});
    @(posedge mclk);
    rst_n <= 1'b1;
    exp_bits.delete();
    rx.bits.delete();
    rx.hold_err = 0;
    write_code(6'h09, 6, 8'h48);
    check_stream();
  endtask : reset_mid_shift

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    bad_count         = 0;
    cmp_count         = 0;
    rst_n             = 1'b0;
    host_write_strobe = 1'b0;
    host_addr         = 6'h00;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 check("idle ready", 8'h01, {7'h00, host_ready});
    check("idle sclk", 8'h00, {7'h00, ser_clk});
    single_codes();
    back_to_back();
    reset_mid_shift();
    end_of_test();
  end

  // roughly a dozen codes at a few hundred cycles each fit well inside this span
  initial begin
    #2000000;
    bad_count++;
    end_of_test();
  end
endmodule : vlcs_store_tb
